// file: verilog/pause_fc_pkg.sv
// constants for the pause flow control buffer block
// assumes a 10 MHz single clock domain and a plain register port
package pause_fc_pkg;
  // fifo size in bytes, fill and sum widths in bits
  localparam int unsigned FIFO_BYTES = 3072;
  localparam int unsigned FILL_W = 12;
  localparam int unsigned SUM_W = 13;
  // transmit cut-through start in bytes
  localparam logic [11:0] CUT_THROUGH_BYTES = 12'h0008;
  // pause frame constants and collision retry limit
  localparam logic [47:0] PAUSE_MCAST = 48'h0180_c200_0001;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [7:0] SLOT_BYTES = 8'h40;
  localparam logic [4:0] MAX_RETRIES = 5'h10;
  // link sleep recovery allowance
  localparam int unsigned RECOVERY_NS = 10000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RECOVERY_CYC = RECOVERY_NS / CLK_PERIOD_NS;
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TYPE = 4'h1;
  localparam logic [3:0] REG_TX_TIMER = 4'h2;
  localparam logic [3:0] REG_REFRESH = 4'h3;
  localparam logic [3:0] REG_HIGH_TH = 4'h4;
  localparam logic [3:0] REG_LOW_TH = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_PAUSE_TMR = 4'h7;
  // control bit positions
  localparam int unsigned CTRL_RX_EN = 0;
  localparam int unsigned CTRL_TX_EN = 1;
  localparam int unsigned CTRL_HALF_DUP = 2;
  // reset values
  localparam logic [15:0] TYPE_RST = 16'h8808;
  localparam logic [15:0] TX_TIMER_RST = 16'h0100;
  localparam logic [15:0] REFRESH_RST = 16'h0080;
  localparam logic [15:0] HIGH_TH_RST = 16'h1000;
  localparam logic [15:0] LOW_TH_RST = 16'h0800;
  // link speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // halt message state
  typedef enum logic [2:0] {
    MSG_IDLE = 3'b001,
    MSG_WAIT = 3'b010,
    MSG_SEND = 3'b100
  } msg_state_e;
endpackage : pause_fc_pkg

// file: verilog/pause_flow_control_buffer.sv
// pause flow control and packet buffer start logic
// assumes byte strobes from host link and wire, one byte per strobe
`timescale 1ns/1ns
`default_nettype none
module pause_flow_control_buffer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic fast_link_i,
  input wire logic host_link_sleep_state_i,
  input wire logic [1:0] link_speed_i,
  input wire logic byte_time_i,
  input wire logic tx_byte_i,
  input wire logic tx_pkt_end_i,
  input wire logic tx_wire_byte_i,
  input wire logic tx_wire_done_i,
  input wire logic defer_i,
  input wire logic collision_i,
  input wire logic [4:0] retry_count_i,
  input wire logic rx_active_i,
  input wire logic rx_byte_i,
  input wire logic rx_pkt_end_i,
  input wire logic rx_host_byte_i,
  input wire logic rx_hdr_valid_i,
  input wire logic [47:0] rx_dest_i,
  input wire logic [47:0] station_addr_i,
  input wire logic [15:0] rx_type_i,
  input wire logic [15:0] rx_opcode_i,
  input wire logic [15:0] rx_timer_i,
  input wire logic host_pause_req_i,
  input wire logic host_pause_zero_i,
  output logic tx_start_o,
  output logic tx_halted_o,
  output logic tx_fifo_full_o,
  output logic rx_fwd_en_o,
  output logic recovery_req_o,
  output logic rx_drop_o,
  output logic msg_valid_o,
  output logic msg_halt_o,
  output logic fwd_pause_o,
  output logic pause_send_o,
  output logic [15:0] pause_timer_val_o,
  output logic [47:0] pause_dest_o
);
  // software registers
  logic [2:0] ctrl_q;
  logic [15:0] type_q, tx_timer_q, refresh_q, high_th_q, low_th_q;
  logic [11:0] tx_fill_q, rx_fill_q;
  logic [11:0] tx_pkt_bytes_q;
  logic tx_pkt_whole_q;
  logic [15:0] pause_tmr_q;
  logic [7:0] slot_cnt_q;
  logic pause_halt_q, coll_halt_q;
  logic [15:0] refresh_cnt_q;
  logic xoff_sent_q;
  logic [7:0] rec_cnt_q;
  pause_fc_pkg::msg_state_e msg_state_q;
  logic msg_flag_q;
  logic halt_now, valid_pause, pause_on, pause_off;
  logic [12:0] fill_sum;
  logic rx_gap;

  // saturating fifo fill update, used by both fifos
  function automatic logic [11:0] fill_next(input logic [11:0] f,
                                            input logic in_b,
                                            input logic out_b);
    logic [11:0] r;
    r = f;
    if (in_b && !out_b && f != 12'(pause_fc_pkg::FIFO_BYTES)) begin
      r = f + 12'h001;
    end else if (!in_b && out_b && f != 12'h000) begin
      r = f - 12'h001;
    end
    return r;
  endfunction

  // register writes; type, timer and refresh are 16 bits
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= 3'h0;
      type_q <= pause_fc_pkg::TYPE_RST;
      tx_timer_q <= pause_fc_pkg::TX_TIMER_RST;
      refresh_q <= pause_fc_pkg::REFRESH_RST;
      high_th_q <= pause_fc_pkg::HIGH_TH_RST;
      low_th_q <= pause_fc_pkg::LOW_TH_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == pause_fc_pkg::REG_CTRL) begin
        ctrl_q <= reg_wdata_i[2:0];
      end else if (reg_addr_i == pause_fc_pkg::REG_TYPE) begin
        type_q <= reg_wdata_i;
      end else if (reg_addr_i == pause_fc_pkg::REG_TX_TIMER) begin
        tx_timer_q <= reg_wdata_i;
      end else if (reg_addr_i == pause_fc_pkg::REG_REFRESH) begin
        refresh_q <= reg_wdata_i;
      end else if (reg_addr_i == pause_fc_pkg::REG_HIGH_TH) begin
        high_th_q <= reg_wdata_i;
      end else if (reg_addr_i == pause_fc_pkg::REG_LOW_TH) begin
        low_th_q <= reg_wdata_i;
      end
    end
  end

  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_addr_i == pause_fc_pkg::REG_CTRL) begin
      reg_rdata_o <= {13'h0000, ctrl_q};
    end else if (reg_addr_i == pause_fc_pkg::REG_TYPE) begin
      reg_rdata_o <= type_q;
    end else if (reg_addr_i == pause_fc_pkg::REG_TX_TIMER) begin
      reg_rdata_o <= tx_timer_q;
    end else if (reg_addr_i == pause_fc_pkg::REG_REFRESH) begin
      reg_rdata_o <= refresh_q;
    end else if (reg_addr_i == pause_fc_pkg::REG_HIGH_TH) begin
      reg_rdata_o <= high_th_q;
    end else if (reg_addr_i == pause_fc_pkg::REG_LOW_TH) begin
      reg_rdata_o <= low_th_q;
    end else if (reg_addr_i == pause_fc_pkg::REG_STATUS) begin
      reg_rdata_o <= {12'h000, coll_halt_q, pause_halt_q, xoff_sent_q,
                      tx_halted_o};
    end else if (reg_addr_i == pause_fc_pkg::REG_PAUSE_TMR) begin
      reg_rdata_o <= pause_tmr_q;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // pause frame classification
  always_comb begin
    valid_pause = rx_hdr_valid_i
      && (rx_dest_i == pause_fc_pkg::PAUSE_MCAST
          || rx_dest_i == station_addr_i)
      && rx_type_i == pause_fc_pkg::PAUSE_TYPE
      && rx_opcode_i == pause_fc_pkg::PAUSE_OPCODE;
    pause_on = valid_pause && ctrl_q[pause_fc_pkg::CTRL_RX_EN]
      && rx_timer_i != 16'h0000;
    pause_off = valid_pause && ctrl_q[pause_fc_pkg::CTRL_RX_EN]
      && rx_timer_i == 16'h0000;
    halt_now = pause_halt_q || coll_halt_q
      || (ctrl_q[pause_fc_pkg::CTRL_HALF_DUP] && (defer_i || collision_i));
    fill_sum = {1'b0, tx_fill_q} + {1'b0, rx_fill_q};
    rx_gap = !rx_active_i;
  end

  // fifo fill levels; tx keeps filling while halted
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_fill_q <= 12'h000;
      rx_fill_q <= 12'h000;
      tx_fifo_full_o <= 1'b0;
      rx_drop_o <= 1'b0;
    end else begin
      tx_fill_q <= fill_next(tx_fill_q, tx_byte_i, tx_wire_byte_i);
      rx_fill_q <= fill_next(rx_fill_q, rx_byte_i, rx_host_byte_i);
      tx_fifo_full_o <= tx_fill_q == 12'(pause_fc_pkg::FIFO_BYTES);
      rx_drop_o <= rx_byte_i
        && rx_fill_q == 12'(pause_fc_pkg::FIFO_BYTES);
    end
  end

  // transmit start: cut-through on fast link, whole packet on slow link
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_pkt_bytes_q <= 12'h000;
      tx_pkt_whole_q <= 1'b0;
      tx_start_o <= 1'b0;
    end else begin
      if (tx_wire_done_i) begin
        tx_pkt_bytes_q <= 12'h000;
        tx_pkt_whole_q <= 1'b0;
      end else begin
        if (tx_byte_i && tx_pkt_bytes_q != 12'hfff) begin
          tx_pkt_bytes_q <= tx_pkt_bytes_q + 12'h001;
        end
        if (tx_pkt_end_i) begin
          tx_pkt_whole_q <= 1'b1;
        end
      end
      // speed does not enter here, only host link type
      tx_start_o <= !halt_now && !tx_wire_done_i && (fast_link_i
        ? tx_pkt_bytes_q >= pause_fc_pkg::CUT_THROUGH_BYTES
        : tx_pkt_whole_q);
    end
  end

  // received pause timer, counted in 64-byte slots
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pause_tmr_q <= 16'h0000;
      slot_cnt_q <= 8'h00;
      pause_halt_q <= 1'b0;
    end else if (pause_on) begin
      pause_tmr_q <= rx_timer_i;
      slot_cnt_q <= 8'h00;
      pause_halt_q <= 1'b1;
    end else if (pause_off) begin
      pause_tmr_q <= 16'h0000;
      pause_halt_q <= 1'b0;
    end else if (pause_halt_q && byte_time_i) begin
      if (slot_cnt_q == pause_fc_pkg::SLOT_BYTES - 8'h01) begin
        slot_cnt_q <= 8'h00;
        pause_tmr_q <= pause_tmr_q - 16'h0001;
        if (pause_tmr_q == 16'h0001) begin
          pause_halt_q <= 1'b0;
        end
      end else begin
        slot_cnt_q <= slot_cnt_q + 8'h01;
      end
    end
  end

  // collision halt held until packet sent or retries used up
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      coll_halt_q <= 1'b0;
    end else if (ctrl_q[pause_fc_pkg::CTRL_HALF_DUP] && collision_i) begin
      coll_halt_q <= 1'b1;
    end else if (tx_wire_done_i
                 || retry_count_i >= pause_fc_pkg::MAX_RETRIES) begin
      coll_halt_q <= 1'b0;
    end
  end

  // side-band halt message, sent only while receive is idle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      msg_state_q <= pause_fc_pkg::MSG_IDLE;
      msg_flag_q <= 1'b0;
      msg_valid_o <= 1'b0;
      msg_halt_o <= 1'b0;
      tx_halted_o <= 1'b0;
    end else begin
      tx_halted_o <= halt_now;
      msg_valid_o <= 1'b0;
      case (msg_state_q)
        pause_fc_pkg::MSG_IDLE: begin
          if (halt_now != msg_flag_q) begin
            msg_state_q <= pause_fc_pkg::MSG_WAIT;
          end
        end
        pause_fc_pkg::MSG_WAIT: begin
          // halt that cleared before the gap needs no message
          if (halt_now == msg_flag_q) begin
            msg_state_q <= pause_fc_pkg::MSG_IDLE;
          end else if (rx_gap) begin
            msg_state_q <= pause_fc_pkg::MSG_SEND;
          end
        end
        pause_fc_pkg::MSG_SEND: begin
          msg_valid_o <= 1'b1;
          msg_halt_o <= halt_now;
          msg_flag_q <= halt_now;
          msg_state_q <= pause_fc_pkg::MSG_IDLE;
        end
        default: msg_state_q <= pause_fc_pkg::MSG_IDLE;
      endcase
    end
  end

  // forward validated pause frames to the controller
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_pause_o <= 1'b0;
    end else begin
      fwd_pause_o <= pause_on || pause_off;
    end
  end

  // link sleep recovery and receive forwarding
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      recovery_req_o <= 1'b0;
      rec_cnt_q <= 8'h00;
      rx_fwd_en_o <= 1'b0;
    end else begin
      if (rx_active_i && host_link_sleep_state_i) begin
        recovery_req_o <= 1'b1;
      end else if (!host_link_sleep_state_i) begin
        recovery_req_o <= 1'b0;
      end
      // count the wait; fifo covers the allowance
      if (!host_link_sleep_state_i) begin
        rec_cnt_q <= 8'h00;
      end else if (recovery_req_o
                   && rec_cnt_q != 8'(pause_fc_pkg::RECOVERY_CYC)) begin
        rec_cnt_q <= rec_cnt_q + 8'h01;
      end
      if (host_link_sleep_state_i) begin
        rx_fwd_en_o <= 1'b0;
      end else if (link_speed_i == pause_fc_pkg::SPD_1000) begin
        rx_fwd_en_o <= rx_fill_q != 12'h000;
      end else if (rx_pkt_end_i) begin
        rx_fwd_en_o <= 1'b1;
      end else if (rx_fill_q == 12'h000) begin
        rx_fwd_en_o <= 1'b0;
      end
    end
  end

  // pause frame generation for both host link modes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pause_send_o <= 1'b0;
      pause_timer_val_o <= 16'h0000;
      pause_dest_o <= 48'h0000_0000_0000;
      xoff_sent_q <= 1'b0;
      refresh_cnt_q <= 16'h0000;
    end else begin
      pause_send_o <= 1'b0;
      pause_dest_o <= pause_fc_pkg::PAUSE_MCAST;
      if (xoff_sent_q && byte_time_i && refresh_cnt_q != 16'hffff) begin
        refresh_cnt_q <= refresh_cnt_q + 16'h0001;
      end
      if (!ctrl_q[pause_fc_pkg::CTRL_TX_EN]) begin
        xoff_sent_q <= 1'b0;
      end else if (fast_link_i) begin
        if (host_pause_req_i && rx_gap) begin
          pause_send_o <= 1'b1;
          pause_timer_val_o <= host_pause_zero_i ? 16'h0000 : tx_timer_q;
        end
      end else if (!xoff_sent_q && fill_sum > high_th_q[12:0]) begin
        pause_send_o <= 1'b1;
        pause_timer_val_o <= tx_timer_q;
        xoff_sent_q <= 1'b1;
        refresh_cnt_q <= 16'h0000;
      end else if (xoff_sent_q && fill_sum < low_th_q[12:0]) begin
        pause_send_o <= 1'b1;
        pause_timer_val_o <= 16'h0000;
        xoff_sent_q <= 1'b0;
      end else if (xoff_sent_q && refresh_cnt_q >= refresh_q) begin
        pause_send_o <= 1'b1;
        pause_timer_val_o <= tx_timer_q;
        refresh_cnt_q <= 16'h0000;
      end
    end
  end

  a_pause_loads_halt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pause_on |=> pause_halt_q && pause_tmr_q == $past(rx_timer_i))
    else $error("pause on did not load timer");
  a_pause_off_resume: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pause_off && !pause_on |=> !pause_halt_q)
    else $error("pause off did not resume");
  a_no_rx_disabled: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !ctrl_q[pause_fc_pkg::CTRL_RX_EN] && !pause_halt_q |=> !pause_halt_q)
    else $error("pause honoured while disabled");
  a_msg_in_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    msg_state_q == pause_fc_pkg::MSG_SEND |-> $past(rx_gap))
    else $error("message outside gap");
  a_halt_msg_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    msg_valid_o |-> msg_halt_o == $past(halt_now))
    else $error("message flag wrong");
  a_tx_start_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_start_o |-> !$past(halt_now) && ($past(fast_link_i)
      ? $past(tx_pkt_bytes_q) >= 12'h008 : $past(tx_pkt_whole_q)))
    else $error("tx start too early");
  a_expire_resume: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pause_halt_q && byte_time_i && !pause_on && !pause_off
      && pause_tmr_q == 16'h0001 && slot_cnt_q == 8'h3f
      |=> !pause_halt_q && pause_tmr_q == 16'h0000)
    else $error("timer expiry missed");
  a_xoff_on_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ctrl_q[pause_fc_pkg::CTRL_TX_EN] && !fast_link_i && !xoff_sent_q
      && fill_sum > high_th_q[12:0]
      |=> pause_send_o && pause_timer_val_o == $past(tx_timer_q))
    else $error("xoff not sent");
  a_coll_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    coll_halt_q && !collision_i && tx_wire_done_i |=> !coll_halt_q)
    else $error("collision halt stuck");

  c_pause_on: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    pause_on ##[1:200] msg_valid_o && msg_halt_o);
  c_pause_off: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    pause_halt_q ##1 pause_off ##[1:50] msg_valid_o && !msg_halt_o);
  c_refresh: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    pause_send_o && xoff_sent_q ##[1:500] pause_send_o && xoff_sent_q);
endmodule // pause_flow_control_buffer
`default_nettype wire

// file: test/lan_ctrl_model.sv
// controller model at the host side of the pause flow control block
// assumes the bench calls its tasks; one clock, strobes one cycle long
`timescale 1ns/1ns
`default_nettype none
module lan_ctrl_model (
  input wire logic sys_clk_i,
  input wire logic rx_active_i,
  input wire logic tx_pause_en_i,
  input wire logic rx_fwd_en_i,
  output logic tx_byte_o,
  output logic tx_pkt_end_o,
  output logic pause_req_o,
  output logic pause_zero_o,
  output logic rx_host_byte_o
);
  initial begin
    tx_byte_o = 1'b0;
    tx_pkt_end_o = 1'b0;
    pause_req_o = 1'b0;
    pause_zero_o = 1'b0;
    rx_host_byte_o = 1'b0;
  end
  // drain received bytes only while forwarding is allowed
  always @(posedge sys_clk_i) begin
    rx_host_byte_o <= rx_fwd_en_i;
  end
  // host bytes, one per strobe; end flag rides on the last one
  task automatic send_bytes(input int n, input logic last);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      tx_byte_o <= 1'b1;
      tx_pkt_end_o <= last && (i == n - 1);
    end
    @(posedge sys_clk_i);
    tx_byte_o <= 1'b0;
    tx_pkt_end_o <= 1'b0;
  endtask
  // command waits for the gap; bounded so a stuck receive cannot hang
  task automatic pause_cmd(input logic zero);
    int n;
    n = 0;
    while (rx_active_i !== 1'b0 && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (tx_pause_en_i === 1'b1) begin
      @(posedge sys_clk_i);
      pause_req_o <= 1'b1;
      pause_zero_o <= zero;
      @(posedge sys_clk_i);
      pause_req_o <= 1'b0;
      pause_zero_o <= 1'b0;
    end
  endtask
endmodule // lan_ctrl_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the pause flow control buffer block
// assumes a 10 MHz clock, async high reset and the controller model
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, ptmr, rtype = 16'h0000;
  logic [15:0] ropc = 16'h0000, rtmr = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, fast = 1'b0, btime = 1'b0, wdone = 1'b0;
  logic wbyte = 1'b0, defer = 1'b0, coll = 1'b0, rx_act = 1'b0;
  logic hdr = 1'b0, pen = 1'b0;
  logic sleep = 1'b0, rxb = 1'b0, rxe = 1'b0, rx_drop;
  logic [1:0] spd = pause_fc_pkg::SPD_1000;
  logic [4:0] retry = 5'h00;
  logic [47:0] dest = 48'h0000_0000_0000, pdest;
  logic [47:0] station = 48'h0000_0a0b_0c0d;
  logic tx_start, halted, fwd_en, rec, msg_v, msg_h, fwd_p, p_send;
  logic tx_byte, tx_end, preq, pzero, hbyte;
  logic s_fwd, s_msg, s_halt, s_send;
  logic [15:0] s_tmr;
  int error_cnt = 0, tests_run = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  pause_flow_control_buffer pause_flow_control_buffer_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .fast_link_i(fast), .host_link_sleep_state_i(sleep),
    .link_speed_i(spd), .byte_time_i(btime), .tx_byte_i(tx_byte),
    .tx_pkt_end_i(tx_end), .tx_wire_byte_i(wbyte), .tx_wire_done_i(wdone),
    .defer_i(defer), .collision_i(coll), .retry_count_i(retry),
    .rx_active_i(rx_act), .rx_byte_i(rxb), .rx_pkt_end_i(rxe),
    .rx_host_byte_i(hbyte), .rx_hdr_valid_i(hdr), .rx_dest_i(dest),
    .station_addr_i(station), .rx_type_i(rtype), .rx_opcode_i(ropc),
    .rx_timer_i(rtmr), .host_pause_req_i(preq), .host_pause_zero_i(pzero),
    .tx_start_o(tx_start), .tx_halted_o(halted), .tx_fifo_full_o(),
    .rx_fwd_en_o(fwd_en), .recovery_req_o(rec), .rx_drop_o(rx_drop),
    .msg_valid_o(msg_v), .msg_halt_o(msg_h), .fwd_pause_o(fwd_p),
    .pause_send_o(p_send), .pause_timer_val_o(ptmr), .pause_dest_o(pdest));
  lan_ctrl_model lan_ctrl_model_inst (
    .sys_clk_i(sys_clk_i), .rx_active_i(rx_act), .tx_pause_en_i(pen),
    .rx_fwd_en_i(fwd_en), .tx_byte_o(tx_byte), .tx_pkt_end_o(tx_end),
    .pause_req_o(preq), .pause_zero_o(pzero), .rx_host_byte_o(hbyte));
  task automatic chk(input string what, input logic [47:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // gather one-cycle pulses; first look lands just after the current edge
  task automatic watch(input int n);
    s_fwd = 1'b0;
    s_msg = 1'b0;
    s_halt = 1'bx;
    s_send = 1'b0;
    repeat (n) begin
      #1;
      s_fwd |= (fwd_p === 1'b1);
      if (msg_v === 1'b1) begin
        s_msg = 1'b1;
        s_halt = msg_h;
      end
      if (p_send === 1'b1) begin
        s_send = 1'b1;
        s_tmr = ptmr;
      end
      @(posedge sys_clk_i);
    end
  endtask
  task automatic frame(input logic [47:0] d, input logic [15:0] t, o, tm);
    @(posedge sys_clk_i);
    rx_act <= 1'b1;
    dest <= d;
    rtype <= t;
    ropc <= o;
    rtmr <= tm;
    hdr <= 1'b1;
    @(posedge sys_clk_i);
    hdr <= 1'b0;
    watch(4);
    rx_act <= 1'b0;
  endtask
  task automatic t_regs;
    logic [15:0] d;
    logic [15:0] tab [8];
    tab = '{16'h0000, pause_fc_pkg::TYPE_RST, pause_fc_pkg::TX_TIMER_RST,
      pause_fc_pkg::REFRESH_RST, pause_fc_pkg::HIGH_TH_RST,
      pause_fc_pkg::LOW_TH_RST, 16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      rd_reg(i[3:0], d);
      chk("reset value", tab[i], d);
    end
    wr_reg(4'h9, 16'hffff);
    rd_reg(4'h9, d);
    chk("unmapped", 16'h0000, d);
    wr_reg(pause_fc_pkg::REG_TX_TIMER, 16'hfedc);
    rd_reg(pause_fc_pkg::REG_TX_TIMER, d);
    chk("tx timer", 16'hfedc, d);
    $display("test regs done");
  endtask
  // management link: combined fill crossing the two thresholds
  task automatic t_mgmt;
    wr_reg(pause_fc_pkg::REG_HIGH_TH, 16'h0004);
    wr_reg(pause_fc_pkg::REG_LOW_TH, 16'h0002);
    wr_reg(pause_fc_pkg::REG_TX_TIMER, 16'h0123);
    wr_reg(pause_fc_pkg::REG_CTRL, 16'h0002);
    fork
      lan_ctrl_model_inst.send_bytes(6, 1'b0);
      watch(14);
    join
    chk("xoff sent", 1'b1, s_send);
    chk("xoff timer", 16'h0123, s_tmr);
    chk("pause dest", pause_fc_pkg::PAUSE_MCAST, pdest);
    fork
      begin
        repeat (6) @(posedge sys_clk_i) wbyte <= 1'b1;
        @(posedge sys_clk_i) wbyte <= 1'b0;
        wdone <= 1'b1; // ends the packet so its byte count starts over
        @(posedge sys_clk_i) wdone <= 1'b0;
      end
      watch(14);
    join
    chk("xon sent", 1'b1, s_send);
    chk("xon timer", 16'h0000, s_tmr);
    wr_reg(pause_fc_pkg::REG_CTRL, 16'h0000);
    $display("test mgmt done");
  endtask
  task automatic t_tx;
    fast <= 1'b1;
    lan_ctrl_model_inst.send_bytes(7, 1'b0);
    watch(2);
    chk("start at 7", 1'b0, tx_start);
    lan_ctrl_model_inst.send_bytes(1, 1'b0);
    watch(3);
    chk("start at 8", 1'b1, tx_start);
    lan_ctrl_model_inst.send_bytes(1, 1'b1);
    @(posedge sys_clk_i) wdone <= 1'b1;
    @(posedge sys_clk_i) wdone <= 1'b0;
    fast <= 1'b0;
    lan_ctrl_model_inst.send_bytes(8, 1'b0);
    watch(3);
    chk("slow early", 1'b0, tx_start);
    lan_ctrl_model_inst.send_bytes(1, 1'b1);
    watch(3);
    chk("slow whole", 1'b1, tx_start);
    @(posedge sys_clk_i) wdone <= 1'b1;
    @(posedge sys_clk_i) wdone <= 1'b0;
    $display("test tx start done");
  endtask
  task automatic t_rx_pause;
    logic [15:0] d;
    logic [47:0] bad_d [3];
    logic [15:0] bad_t [3], bad_o [3];
    bad_d = '{48'h0180_c200_0002, 48'h0180_c200_0001, 48'h0180_c200_0001};
    bad_t = '{16'h8808, 16'h8809, 16'h8808};
    bad_o = '{16'h0001, 16'h0001, 16'h0002};
    frame(pause_fc_pkg::PAUSE_MCAST, 16'h8808, 16'h0001, 16'h0005);
    chk("disabled fwd", 1'b0, s_fwd);
    chk("disabled halt", 1'b0, halted);
    wr_reg(pause_fc_pkg::REG_CTRL, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      frame(bad_d[i], bad_t[i], bad_o[i], 16'h0005);
      chk("bad fwd", 1'b0, s_fwd);
      chk("bad halt", 1'b0, halted);
    end
    frame(pause_fc_pkg::PAUSE_MCAST, 16'h8808, 16'h0001, 16'h0005);
    chk("xoff fwd", 1'b1, s_fwd);
    chk("xoff halt", 1'b1, halted);
    watch(8);
    chk("xoff msg", 1'b1, s_msg);
    chk("xoff flag", 1'b1, s_halt);
    rd_reg(pause_fc_pkg::REG_PAUSE_TMR, d);
    chk("timer load", 16'h0005, d);
    frame(station, 16'h8808, 16'h0001, 16'h0000);
    chk("xon fwd", 1'b1, s_fwd);
    chk("xon resume", 1'b0, halted);
    watch(8);
    chk("xon msg", 1'b1, s_msg);
    chk("xon flag", 1'b0, s_halt);
    $display("test rx pause done");
  endtask
  task automatic t_expiry;
    frame(pause_fc_pkg::PAUSE_MCAST, 16'h8808, 16'h0001, 16'h0001);
    watch(8);
    repeat (63) begin
      @(posedge sys_clk_i) btime <= 1'b1;
      @(posedge sys_clk_i) btime <= 1'b0;
    end
    chk("still paused", 1'b1, halted);
    @(posedge sys_clk_i) btime <= 1'b1;
    @(posedge sys_clk_i) btime <= 1'b0;
    watch(3);
    chk("expired", 1'b0, halted);
    $display("test expiry done");
  endtask
  task automatic t_coll;
    wr_reg(pause_fc_pkg::REG_CTRL, 16'h0004);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk_i) coll <= 1'b1;
      @(posedge sys_clk_i) coll <= 1'b0;
      watch(8);
      chk("coll halt", 1'b1, halted);
      chk("coll msg", 1'b1, s_halt);
      @(posedge sys_clk_i);
      if (k == 0) wdone <= 1'b1;
      else retry <= pause_fc_pkg::MAX_RETRIES;
      @(posedge sys_clk_i) wdone <= 1'b0;
      watch(8);
      retry <= 5'h00;
      chk("clear msg", 1'b1, s_msg);
      chk("clear flag", 1'b0, s_halt);
    end
    @(posedge sys_clk_i) defer <= 1'b1;
    watch(2);
    chk("defer halt", 1'b1, halted);
    defer <= 1'b0;
    $display("test collision done");
  endtask
  // slow speed waits for the packet end; a sleeping link asks for recovery
  task automatic t_rx;
    spd <= pause_fc_pkg::SPD_100;
    rx_act <= 1'b1;
    rxb <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rxb <= 1'b0;
    watch(3);
    chk("fwd early", 1'b0, fwd_en);
    rxe <= 1'b1;
    @(posedge sys_clk_i) rxe <= 1'b0;
    watch(2);
    chk("fwd whole", 1'b1, fwd_en);
    watch(8);
    sleep <= 1'b1;
    spd <= pause_fc_pkg::SPD_1000;
    rxb <= 1'b1;
    repeat (3073) @(posedge sys_clk_i);
    rxb <= 1'b0;
    sleep <= 1'b0;
    rx_act <= 1'b0;
    #1;
    chk("recovery", 1'b1, rec);
    chk("asleep fwd", 1'b0, fwd_en);
    chk("rx drop", 1'b1, rx_drop);
    watch(2);
    chk("fwd awake", 1'b1, fwd_en);
    chk("recovered", 1'b0, rec);
    $display("test rx done");
  endtask
  task automatic t_host_pause;
    pen <= 1'b1;
    fast <= 1'b1;
    wr_reg(pause_fc_pkg::REG_CTRL, 16'h0003);
    lan_ctrl_model_inst.pause_cmd(1'b0);
    watch(4);
    chk("cmd send", 1'b1, s_send);
    chk("cmd timer", 16'h0123, s_tmr);
    lan_ctrl_model_inst.pause_cmd(1'b1);
    watch(4);
    chk("cmd zero", 16'h0000, s_tmr);
    rx_act <= 1'b1;
    lan_ctrl_model_inst.pause_cmd(1'b0);
    watch(4);
    rx_act <= 1'b0;
    chk("cmd mid packet", 1'b0, s_send);
    $display("test host pause done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog sized well above the few thousand cycles the tests need
  initial begin
    #(20000 * 100);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_mgmt;
    t_tx;
    t_rx_pause;
    t_expiry;
    t_coll;
    t_rx;
    t_host_pause;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
